// ===== src/pd_pkg.sv
/*
 * Constants and types for the link partner power detection block.
 * Assumes a 40 MHz core clock and a 16-bit management register port.
 */
package pd_pkg;

    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_INT_ENABLE = 5'h12;
    localparam logic [4:0] OFS_INT_FLAG = 5'h13;
    localparam logic [4:0] OFS_EXT_CONTROL = 5'h14;
    localparam logic [4:0] OFS_STATUS_DELAY = 5'h1b;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_IE_CHANGE = 2;
    localparam int BIT_FLAG_CHANGE = 2;
    localparam int BIT_DETECT_EN = 2;
    localparam int BIT_NEED_POWER = 4;
    localparam int DELAY_LSB = 5;
    localparam int DELAY_MSB = 8;
    localparam logic [3:0] DELAY_RST = 4'h4;
    localparam logic [3:0] DELAY_ZERO = 4'h0;
    localparam logic [15:0] RDATA_ZERO = 16'h0000;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_HZ = 40000000;
    localparam int DROP_UNIT_MS = 5000;
    localparam int TICK_CYCLES_DEF = DROP_UNIT_MS * (CLK_HZ / 1000);
    localparam int TB_WIDTH = 28;

    // ************************************************************
    // Detection states.
    // ************************************************************
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WATCH = 2'b01,
        ST_PROBE = 2'b11,
        ST_POWERED = 2'b10
    } detect_state_type;

endpackage

// ===== src/power_timebase.sv
/*
 * Timebase that pulses once per drop-delay unit of core clock cycles.
 * Assumes restart is a synchronous level from the controller.
 */
`timescale 1ns/1ps
module power_timebase #(
    parameter int TICK_CYCLES = pd_pkg::TICK_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic restart,
    output logic tick
);

    typedef struct packed {
        logic [pd_pkg::TB_WIDTH-1:0] cnt;
        logic tick;
    } tb_state_type;

    tb_state_type cur_q;
    tb_state_type cur_d;

    // ************************************************************
    // Counter.
    // ************************************************************
    always_comb begin
        cur_d = cur_q;
        cur_d.tick = 1'b0;
        if (restart) begin
            cur_d.cnt = '0;
        end else if (cur_q.cnt == pd_pkg::TB_WIDTH'(TICK_CYCLES - 1)) begin
            cur_d.cnt = '0;
            cur_d.tick = 1'b1;
        end else begin
            cur_d.cnt = cur_q.cnt + pd_pkg::TB_WIDTH'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign tick = cur_q.tick;

endmodule

// ===== src/drop_timer.sv
/*
 * Counts timebase ticks while a drop is pending and flags expiry.
 * Assumes tick is one cycle long and run falls when the wait ends.
 */
`timescale 1ns/1ps
module drop_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic tick,
    input wire logic [3:0] delay,
    output logic expire
);

    typedef struct packed {
        logic [3:0] cnt;
    } dt_state_type;

    dt_state_type cur_q;
    dt_state_type cur_d;
    logic [3:0] cnt_inc;

    // ************************************************************
    // Tick counter.
    // ************************************************************
    always_comb begin
        cur_d = cur_q;
        cnt_inc = cur_q.cnt + 4'h1;
        expire = 1'b0;
        if (!run) begin
            cur_d.cnt = 4'h0;
        end else if (tick) begin
            cur_d.cnt = cnt_inc;
            if (cnt_inc >= delay) begin
                expire = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

endmodule

// ===== src/power_detect_ctrl.sv
/*
 * Control and status logic for detecting whether a link partner needs power.
 * Assumes synchronous partner activity and filter-seen inputs from the line logic.
 */
// Our own choice: the strobed register port.
// Overview of operation
// - A written enable value takes effect only at the next soft reset.
// - Enable 0 disables, 1 enables detection; hardware reset 0, soft reset updates.
// - When enabled, watch for partner activity; active partner means no probing.
// - A silent partner is probed with detection pulses.
// - A partner showing a low-pass filter is classed as needing power.
// - The need-power status bit rises as soon as such a partner is seen.
// - Interrupt enable bit, reset 0 by hardware, kept by soft reset.
// - Status change sets the change flag; interrupt only when enabled.
// - After the filter is lost, wait five seconds times the delay field.
// - Delay field resets to four, kept across soft reset.
// - Delay zero drops the status bit at once.
// - Status bit and change flag clear on hardware and soft reset.
`timescale 1ns/1ps
module power_detect_ctrl #(
    parameter int TICK_CYCLES = pd_pkg::TICK_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic partner_activity,
    input wire logic filter_detected,
    output logic detect_pulse_en,
    output logic irq
);

    typedef struct packed {
        logic en_pending;
        logic en_active;
        logic ie;
        logic flag;
        logic need_power;
        logic [3:0] delay;
        pd_pkg::detect_state_type state;
        logic pulse;
        logic [15:0] rdata;
    } ctrl_state_type;

    localparam ctrl_state_type CTRL_RST = '{
        en_pending: 1'b0,
        en_active: 1'b0,
        ie: 1'b0,
        flag: 1'b0,
        need_power: 1'b0,
        delay: pd_pkg::DELAY_RST,
        state: pd_pkg::ST_OFF,
        pulse: 1'b0,
        rdata: pd_pkg::RDATA_ZERO
    };

    ctrl_state_type cur_q;
    ctrl_state_type cur_d;
    logic sw_rst;
    logic seen;
    logic run;
    logic tick;
    logic expire;

    // ************************************************************
    // Timing of the status drop.
    // ************************************************************
    // wait restarts whenever the filter is seen.
    assign run = cur_q.need_power && !seen && (cur_q.delay != pd_pkg::DELAY_ZERO);

    power_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .mclk(mclk),
        .rst_n(rst_n),
        .restart(!run),
        .tick(tick)
    );

    drop_timer u_drop_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(run),
        .tick(tick),
        .delay(cur_q.delay),
        .expire(expire)
    );

    // ************************************************************
    // Register port and detection sequence.
    // ************************************************************
    always_comb begin
        cur_d = cur_q;
        cur_d.rdata = pd_pkg::RDATA_ZERO;
        sw_rst = reg_wr && (reg_addr == pd_pkg::OFS_CONTROL)
            && reg_wdata[pd_pkg::BIT_SOFT_RESET];
        seen = cur_q.pulse && filter_detected && !partner_activity;

        if (reg_wr) begin
            case (reg_addr)
                pd_pkg::OFS_INT_ENABLE: begin
                    cur_d.ie = reg_wdata[pd_pkg::BIT_IE_CHANGE];
                end
                pd_pkg::OFS_EXT_CONTROL: begin
                    cur_d.en_pending = reg_wdata[pd_pkg::BIT_DETECT_EN];
                end
                pd_pkg::OFS_STATUS_DELAY: begin
                    cur_d.delay = reg_wdata[pd_pkg::DELAY_MSB:pd_pkg::DELAY_LSB];
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                pd_pkg::OFS_INT_ENABLE: begin
                    cur_d.rdata[pd_pkg::BIT_IE_CHANGE] = cur_q.ie;
                end
                pd_pkg::OFS_INT_FLAG: begin
                    cur_d.rdata[pd_pkg::BIT_FLAG_CHANGE] = cur_q.flag;
                    cur_d.flag = 1'b0;
                end
                pd_pkg::OFS_EXT_CONTROL: begin
                    cur_d.rdata[pd_pkg::BIT_DETECT_EN] = cur_q.en_pending;
                end
                pd_pkg::OFS_STATUS_DELAY: begin
                    cur_d.rdata[pd_pkg::BIT_NEED_POWER] = cur_q.need_power;
                    cur_d.rdata[pd_pkg::DELAY_MSB:pd_pkg::DELAY_LSB] = cur_q.delay;
                end
                default: begin
                end
            endcase
        end

        case (cur_q.state)
            pd_pkg::ST_OFF: begin
                if (cur_q.en_active) begin
                    cur_d.state = pd_pkg::ST_WATCH;
                end
            end
            pd_pkg::ST_WATCH: begin
                if (!partner_activity) begin
                    cur_d.state = pd_pkg::ST_PROBE;
                end
            end
            pd_pkg::ST_PROBE: begin
                if (partner_activity) begin
                    cur_d.state = pd_pkg::ST_WATCH;
                end else if (seen) begin
                    // filter response classes partner as powered.
                    cur_d.state = pd_pkg::ST_POWERED;
                end
            end
            pd_pkg::ST_POWERED: begin
                if (partner_activity) begin
                    cur_d.state = pd_pkg::ST_WATCH;
                end else if (!seen && (expire || cur_q.delay == pd_pkg::DELAY_ZERO)) begin
                    cur_d.state = pd_pkg::ST_PROBE;
                end
            end
            default: begin
                cur_d.state = pd_pkg::ST_OFF;
            end
        endcase
        if (!cur_q.en_active) begin
            cur_d.state = pd_pkg::ST_OFF;
        end

        // status rises as soon as the filter is seen.
        if (seen && cur_q.state == pd_pkg::ST_PROBE) begin
            cur_d.need_power = 1'b1;
        end
        // delayed drop; immediate when delay is zero.
        if (cur_q.need_power && !seen
            && (expire || cur_q.delay == pd_pkg::DELAY_ZERO)) begin
            cur_d.need_power = 1'b0;
        end

        // a status rise or drop sets the flag, winning over a read clear but not over a soft reset.
        if (cur_d.need_power != cur_q.need_power) begin
            cur_d.flag = 1'b1;
        end

        // soft reset applies the pending enable.
        if (sw_rst) begin
            // enable updates from the written value.
            cur_d.en_active = cur_q.en_pending;
            // soft reset clears status and flag.
            cur_d.need_power = 1'b0;
            cur_d.flag = 1'b0;
            cur_d.state = pd_pkg::ST_OFF;
        end

        cur_d.pulse = (cur_d.state == pd_pkg::ST_PROBE)
            || (cur_d.state == pd_pkg::ST_POWERED);
    end

    // hardware reset loads the documented values.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_q <= CTRL_RST;
        end else begin
            cur_q <= cur_d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign reg_rdata = cur_q.rdata;
    assign detect_pulse_en = cur_q.pulse;
    // interrupt gated by the enable bit.
    assign irq = cur_q.flag && cur_q.ie;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_enable_waits_reset: assert property (
        !sw_rst |=> $stable(cur_q.en_active))
        else $error("enable changed without soft reset");

    a_enable_updates: assert property (
        sw_rst |=> cur_q.en_active == $past(cur_q.en_pending))
        else $error("soft reset did not apply enable");

    a_activity_stops_pulses: assert property (
        partner_activity && !sw_rst |=> !detect_pulse_en)
        else $error("pulses sent to an active partner");

    a_silence_probes: assert property (
        cur_q.state == pd_pkg::ST_WATCH && cur_q.en_active && !partner_activity && !sw_rst
        |=> detect_pulse_en)
        else $error("silent partner not probed");

    a_filter_sets_status: assert property (
        cur_q.state == pd_pkg::ST_PROBE && filter_detected && !partner_activity && !sw_rst
        |=> cur_q.need_power && cur_q.state == pd_pkg::ST_POWERED)
        else $error("status did not rise on filter");

    a_ie_retained: assert property (
        sw_rst |=> cur_q.ie == $past(cur_q.ie))
        else $error("soft reset changed interrupt enable");

    a_change_sets_flag: assert property (
        $changed(cur_q.need_power) && !$past(sw_rst) |-> cur_q.flag)
        else $error("status change did not set flag");

    a_irq_gated: assert property (
        !cur_q.ie |-> !irq)
        else $error("interrupt raised while disabled");

    a_no_early_drop: assert property (
        $fell(cur_q.need_power) && !$past(sw_rst) && $past(cur_q.delay) != pd_pkg::DELAY_ZERO
        |-> $past(expire))
        else $error("status dropped before delay");

    a_delay_retained: assert property (
        sw_rst |=> cur_q.delay == $past(cur_q.delay))
        else $error("soft reset changed delay");

    a_zero_drop: assert property (
        cur_q.need_power && !seen && cur_q.delay == pd_pkg::DELAY_ZERO
        |=> !cur_q.need_power)
        else $error("zero delay did not drop at once");

    a_soft_clears: assert property (
        sw_rst |=> !cur_q.need_power && !cur_q.flag)
        else $error("soft reset left status or flag");

    a_read_clears: assert property (
        reg_rd && reg_addr == pd_pkg::OFS_INT_FLAG && cur_d.need_power == cur_q.need_power
        |=> !cur_q.flag)
        else $error("flag read did not clear");

    a_wait_restarts: assert property (
        seen |=> u_drop_timer.cur_q.cnt == 4'h0)
        else $error("drop wait not restarted");

    a_timebase_restart: assert property (
        !run |=> u_timebase.cur_q.cnt == '0)
        else $error("timebase not restarted");

    a_irq_on_change: assert property (
        $changed(cur_q.need_power) && !$past(sw_rst) && cur_q.ie |-> irq)
        else $error("status change raised no interrupt");

    a_pulses_need_enable: assert property (
        !cur_q.en_active |=> !detect_pulse_en)
        else $error("pulses sent while detection disabled");

    a_status_on_filter: assert property (
        $rose(cur_q.need_power) |-> $past(filter_detected) && !$past(partner_activity))
        else $error("status rose without filter response");

    a_drop_on_expire: assert property (
        cur_q.need_power && !seen && expire |=> !cur_q.need_power)
        else $error("status kept after delay expired");

    a_pending_kept: assert property (
        sw_rst |=> cur_q.en_pending == $past(cur_q.en_pending))
        else $error("soft reset changed pending enable");

    a_zero_drop_cause: assert property (
        $fell(cur_q.need_power) && !$past(sw_rst) && $past(cur_q.delay) == pd_pkg::DELAY_ZERO
        |-> !$past(seen))
        else $error("status dropped while filter seen");

    a_watch_quiet: assert property (
        cur_q.state == pd_pkg::ST_WATCH |-> !detect_pulse_en)
        else $error("pulses sent while watching partner");

    c_status_rise: cover property (
        $rose(cur_q.need_power));

    c_delayed_drop: cover property (
        expire ##1 !cur_q.need_power);

    c_irq_raised: cover property (
        $rose(irq));

    c_flag_read: cover property (
        reg_rd && reg_addr == pd_pkg::OFS_INT_FLAG && cur_q.flag);

    c_zero_drop: cover property (
        $fell(cur_q.need_power) && cur_q.delay == pd_pkg::DELAY_ZERO);

endmodule

// ===== dv/link_partner_model.sv
/*
 * Behavioural link partner on the far end of the cable.
 * Assumes the bench commands whether it talks and whether a filter is fitted.
 */
`timescale 1ns/1ps
module link_partner_model (
    input wire logic mclk,
    input wire logic detect_pulse_en,
    input wire logic talking,
    input wire logic has_filter,
    output logic partner_activity,
    output logic filter_detected
);
    // ************************************************************
    // Line behaviour.
    // ************************************************************
    // A fitted filter returns pulses even while the partner talks.
    assign partner_activity = talking;
    always @(posedge mclk) begin
        filter_detected <= detect_pulse_en & has_filter;
    end
endmodule

// ===== dv/power_detect_ctrl_bench.sv
/*
 * Self-checking bench for the power detection control block.
 * Assumes a shortened timebase of 20 cycles per drop-delay unit.
 */
`timescale 1ns/1ps
module power_detect_ctrl_bench;
    localparam int TICKS = 20;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic partner_activity;
    logic filter_detected;
    logic detect_pulse_en;
    logic irq;
    logic talking = 1'b0;
    logic has_filter = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    always #12.5 mclk = ~mclk;

    power_detect_ctrl #(.TICK_CYCLES(TICKS)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .partner_activity(partner_activity), .filter_detected(filter_detected),
        .detect_pulse_en(detect_pulse_en), .irq(irq)
    );

    link_partner_model u_partner (
        .mclk(mclk), .detect_pulse_en(detect_pulse_en), .talking(talking),
        .has_filter(has_filter), .partner_activity(partner_activity),
        .filter_detected(filter_detected)
    );

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk_word(what, exp, reg_rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic t_reset();
        rd(pd_pkg::OFS_INT_ENABLE, 16'h0000, "int enable");
        rd(pd_pkg::OFS_INT_FLAG, 16'h0000, "change flag");
        rd(pd_pkg::OFS_EXT_CONTROL, 16'h0000, "enable");
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0080, "status delay");
        rd(5'h05, 16'h0000, "unmapped");
        chk_pin("pulses", 1'b0, detect_pulse_en);
        chk_pin("irq", 1'b0, irq);
    endtask

    task automatic t_enable();
        wr(pd_pkg::OFS_EXT_CONTROL, 16'h0004);
        wait_cyc(6);
        chk_pin("pulses", 1'b0, detect_pulse_en);
        rd(pd_pkg::OFS_EXT_CONTROL, 16'h0004, "enable");
        wr(pd_pkg::OFS_CONTROL, 16'h8000);
        wait_cyc(4);
        chk_pin("pulses", 1'b1, detect_pulse_en);
    endtask

    task automatic t_detect();
        wr(pd_pkg::OFS_INT_ENABLE, 16'h0004);
        @(posedge mclk);
        talking <= 1'b1;
        has_filter <= 1'b1;
        wait_cyc(4);
        chk_pin("pulses", 1'b0, detect_pulse_en);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0080, "status delay");
        chk_pin("irq", 1'b0, irq);
        @(posedge mclk);
        talking <= 1'b0;
        wait_cyc(5);
        chk_pin("irq", 1'b1, irq);
        rd(pd_pkg::OFS_INT_FLAG, 16'h0004, "change flag");
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0090, "status delay");
        chk_pin("irq", 1'b0, irq);
        rd(pd_pkg::OFS_INT_FLAG, 16'h0000, "change flag");
    endtask

    task automatic t_drop();
        wr(pd_pkg::OFS_STATUS_DELAY, 16'h0040);
        wr(pd_pkg::OFS_INT_ENABLE, 16'h0000);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0050, "status delay");
        @(posedge mclk);
        has_filter <= 1'b0;
        wait_cyc(30);
        has_filter <= 1'b1;
        wait_cyc(4);
        has_filter <= 1'b0;
        wait_cyc(30);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0050, "status delay");
        wait_cyc(14);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0040, "status delay");
        chk_pin("irq", 1'b0, irq);
        rd(pd_pkg::OFS_INT_FLAG, 16'h0004, "change flag");
    endtask

    task automatic t_zero();
        @(posedge mclk);
        has_filter <= 1'b1;
        wait_cyc(4);
        wr(pd_pkg::OFS_STATUS_DELAY, 16'h0000);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0010, "status delay");
        @(posedge mclk);
        has_filter <= 1'b0;
        wait_cyc(3);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0000, "status delay");
    endtask

    task automatic t_soft();
        wr(pd_pkg::OFS_STATUS_DELAY, 16'h0060);
        rd(pd_pkg::OFS_INT_FLAG, 16'h0004, "change flag");
        wr(pd_pkg::OFS_INT_ENABLE, 16'h0004);
        wait_cyc(1);
        chk_pin("irq", 1'b0, irq);
        @(posedge mclk);
        has_filter <= 1'b1;
        wait_cyc(4);
        chk_pin("irq", 1'b1, irq);
        wr(pd_pkg::OFS_EXT_CONTROL, 16'h0000);
        has_filter <= 1'b0;
        wr(pd_pkg::OFS_CONTROL, 16'h8000);
        wait_cyc(4);
        chk_pin("irq", 1'b0, irq);
        chk_pin("pulses", 1'b0, detect_pulse_en);
        rd(pd_pkg::OFS_STATUS_DELAY, 16'h0060, "status delay");
        rd(pd_pkg::OFS_INT_ENABLE, 16'h0004, "int enable");
        rd(pd_pkg::OFS_INT_FLAG, 16'h0000, "change flag");
    endtask

    // ************************************************************
    // Run control.
    // ************************************************************
    always @(posedge mclk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_detect();
        t_drop();
        t_zero();
        t_soft();
        end_of_test();
    end
endmodule
